// ===== verilog/qed_decoder.sv
// quadrature encoder decoder with position count and angle output
//
// Operation
// - mode bit 0 inverts the A input
// - mode bit 1 inverts the B input
// - mode bit 2 inverts the N index input
// - bit 3 low: index follows N; high: needs N, A, B together
// - index event: bit 8 low latches count, high reloads count from latch
// - mode bit 12 low counts positive, high counts negative
// - 24-bit software pulses-per-revolution setting
// - 24-bit position count wraps modulo pulses-per-revolution
// - software write overwrites the position count
// - index event captures count into latch; a count cleared in that cycle latches its old value
// - software write to latch gives the reload value for next index
// - mechanical angle is count times 2^16 over ppr plus offset
// - electrical angle is mechanical angle times pole pairs plus offset
// - offset register bits 15:0 hold signed mechanical offset
// - motor config bits 15:0 hold unsigned pole-pair count
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module qed_decoder #(
  parameter int CNT_W = 24,
  parameter int ANG_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // position and angle outputs
  output logic [CNT_W-1:0] position,
  output logic [ANG_W-1:0] phi_mech,
  output logic [ANG_W-1:0] phi_elec,
  output logic index_event
);

  localparam int NUM_W = CNT_W + ANG_W;

  // ==========================================================
  // registers
  logic [31:0] mode_q;
  logic [CNT_W-1:0] ppr_q;
  logic [15:0] poles_q;
  logic [31:0] offsets_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] latch_q;
  logic [CNT_W-1:0] latch_d;
  logic [1:0] ab_q;
  logic [1:0] ab_prev_q;
  logic idx_prev_q;
  logic [ANG_W-1:0] phi_m_q;
  logic [ANG_W-1:0] phi_e_q;

  // ==========================================================
  // register decode
  wire wr_mode = reg_wr && reg_addr == qed_pkg::QED_ADDR_MODE;
  wire wr_ppr = reg_wr && reg_addr == qed_pkg::QED_ADDR_PPR;
  wire wr_poles = reg_wr && reg_addr == qed_pkg::QED_ADDR_MOTOR_CFG;
  wire wr_count = reg_wr && reg_addr == qed_pkg::QED_ADDR_COUNT;
  wire wr_latch = reg_wr && reg_addr == qed_pkg::QED_ADDR_COUNT_IDX;
  wire wr_offsets = reg_wr && reg_addr == qed_pkg::QED_ADDR_OFFSETS;

  // ==========================================================
  // mode fields
  wire pol_a = mode_q[qed_pkg::QED_MODE_APOL];
  wire pol_b = mode_q[qed_pkg::QED_MODE_BPOL];
  wire pol_n = mode_q[qed_pkg::QED_MODE_NPOL];
  wire qualify_all = mode_q[qed_pkg::QED_MODE_QUALIFY];
  wire reload_mode = mode_q[qed_pkg::QED_MODE_RELOAD];
  wire dir_neg = mode_q[qed_pkg::QED_MODE_DIR];

  // ==========================================================
  // input polarity
  wire a_pol = enc_a ^ pol_a;
  wire b_pol = enc_b ^ pol_b;
  wire n_pol = enc_n ^ pol_n;

  // ==========================================================
  // index qualification and edge detection
  wire idx_level = n_pol && (!qualify_all || (ab_q[1] && ab_q[0]));
  wire idx_hit = idx_level && !idx_prev_q;

  // ==========================================================
  // quadrature phase: gray code to phase number
  wire [1:0] ph_now = {ab_q[1], ab_q[1] ^ ab_q[0]};
  wire [1:0] ph_old = {ab_prev_q[1], ab_prev_q[1] ^ ab_prev_q[0]};
  wire [1:0] ph_diff = ph_now - ph_old;
  wire step_fwd = ph_diff == 2'h1;
  wire step_back = ph_diff == 2'h3; // 2 is a skipped phase, ignored
  wire step_up = dir_neg ? step_back : step_fwd;
  wire step_dn = dir_neg ? step_fwd : step_back;

  // ==========================================================
  // modulo counting
  wire [CNT_W-1:0] ppr_last = ppr_q - 1'b1;
  wire at_top = count_q >= ppr_last;
  wire [CNT_W-1:0] count_inc = at_top ? '0 : count_q + 1'b1;
  wire [CNT_W-1:0] count_dec = (count_q == '0) ? ppr_last : count_q - 1'b1;

  // next count: software write, then index reload, then step
  always_comb
  begin
    count_d = count_q;
    if (wr_count)
      count_d = reg_wdata[CNT_W-1:0];
    else if (idx_hit && reload_mode)
      count_d = latch_q;
    else if (step_up)
      count_d = count_inc;
    else if (step_dn)
      count_d = count_dec;
  end

  // next index latch: capture on index beats a software write
  always_comb
  begin
    latch_d = latch_q;
    if (idx_hit && !reload_mode)
      latch_d = count_q;
    else if (wr_latch)
      latch_d = reg_wdata[CNT_W-1:0];
  end

  // ==========================================================
  // mode register; bits outside the mask always read zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
      mode_q <= qed_pkg::QED_MODE_RST;
    else if (wr_mode)
      mode_q <= reg_wdata & qed_pkg::QED_MODE_MASK;
  end

  // pulses per revolution; zero lets the count wrap at full range
  always_ff @(posedge clk)
  begin
    if (!rstn)
      ppr_q <= qed_pkg::QED_PPR_RST;
    else if (wr_ppr)
      ppr_q <= reg_wdata[CNT_W-1:0];
  end

  // pole-pair count for the electrical angle
  always_ff @(posedge clk)
  begin
    if (!rstn)
      poles_q <= qed_pkg::QED_POLES_RST;
    else if (wr_poles)
      poles_q <= reg_wdata[15:0];
  end

  // both angle offsets in one word
  always_ff @(posedge clk)
  begin
    if (!rstn)
      offsets_q <= qed_pkg::QED_OFFSETS_RST;
    else if (wr_offsets)
      offsets_q <= reg_wdata;
  end

  // ==========================================================
  // input sampling and edge history
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ab_q <= 2'b00;
      ab_prev_q <= 2'b00;
    end
    else
    begin
      ab_q <= {a_pol, b_pol};
      ab_prev_q <= ab_q;
    end
  end

  // index level history; a level held high gives one event only
  always_ff @(posedge clk)
  begin
    if (!rstn)
      idx_prev_q <= 1'b0;
    else
      idx_prev_q <= idx_level;
  end

  // ==========================================================
  // position count
  always_ff @(posedge clk)
  begin
    if (!rstn)
      count_q <= qed_pkg::QED_COUNT_RST;
    else
      count_q <= count_d;
  end

  // index latch
  always_ff @(posedge clk)
  begin
    if (!rstn)
      latch_q <= qed_pkg::QED_COUNT_RST;
    else
      latch_q <= latch_d;
  end

  // index pulse, one cycle after the edge that took the index
  always_ff @(posedge clk)
  begin
    if (!rstn)
      index_event <= 1'b0;
    else
      index_event <= idx_hit;
  end

  // ==========================================================
  // mechanical angle: count * 2^16 / ppr, recomputed continuously
  logic div_busy;
  logic div_done;
  logic [NUM_W-1:0] div_quot;
  wire [NUM_W-1:0] div_numer = {count_q, {ANG_W{1'b0}}};

  qed_divider #(
    .NUM_W(NUM_W),
    .DEN_W(CNT_W)
  ) u_div (
    .clk(clk),
    .rstn(rstn),
    .start(!div_busy),
    .numer(div_numer),
    .denom(ppr_q),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // ==========================================================
  // offsets and pole-pair scaling
  wire [ANG_W-1:0] m_off = offsets_q[qed_pkg::QED_M_LSB +: ANG_W];
  wire [ANG_W-1:0] e_off = offsets_q[qed_pkg::QED_E_LSB +: ANG_W];
  wire [ANG_W-1:0] phi_m_d = div_quot[ANG_W-1:0] + m_off;
  wire [31:0] phi_prod = phi_m_d * poles_q;
  wire [ANG_W-1:0] phi_e_d = phi_prod[ANG_W-1:0] + e_off;

  // mechanical angle, updated when the divider finishes
  always_ff @(posedge clk)
  begin
    if (!rstn)
      phi_m_q <= '0;
    else if (div_done)
      phi_m_q <= phi_m_d;
  end

  // electrical angle, taken in the same cycle as the mechanical one
  always_ff @(posedge clk)
  begin
    if (!rstn)
      phi_e_q <= '0;
    else if (div_done)
      phi_e_q <= phi_e_d;
  end

  // ==========================================================
  // read data selection; unmapped places read zero
  wire sel_poles = reg_addr == qed_pkg::QED_ADDR_MOTOR_CFG;
  wire sel_mode = reg_addr == qed_pkg::QED_ADDR_MODE;
  wire sel_ppr = reg_addr == qed_pkg::QED_ADDR_PPR;
  wire sel_count = reg_addr == qed_pkg::QED_ADDR_COUNT;
  wire sel_latch = reg_addr == qed_pkg::QED_ADDR_COUNT_IDX;
  wire sel_offsets = reg_addr == qed_pkg::QED_ADDR_OFFSETS;
  wire sel_angles = reg_addr == qed_pkg::QED_ADDR_ANGLES;

  // one-hot selects, so an or of masked words is enough
  wire [31:0] rd_mux = ({32{sel_poles}} & {16'h0000, poles_q})
    | ({32{sel_mode}} & mode_q)
    | ({32{sel_ppr}} & {8'h00, ppr_q})
    | ({32{sel_count}} & {8'h00, count_q})
    | ({32{sel_latch}} & {8'h00, latch_q})
    | ({32{sel_offsets}} & offsets_q)
    | ({32{sel_angles}} & {phi_e_q, phi_m_q});

  // read data stand for one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rstn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ==========================================================
  // outputs
  assign position = count_q;
  assign phi_mech = phi_m_q;
  assign phi_elec = phi_e_q;

endmodule // qed_decoder
`default_nettype wire

// ===== common/qed_pkg.sv
// shared constants of the quadrature encoder decoder
package qed_pkg;

  // ==========================================================
  // register addresses (plain port, printed offsets)
  localparam logic [7:0] QED_ADDR_MOTOR_CFG = 8'h1B;
  localparam logic [7:0] QED_ADDR_MODE = 8'h25;
  localparam logic [7:0] QED_ADDR_PPR = 8'h26;
  localparam logic [7:0] QED_ADDR_COUNT = 8'h27;
  localparam logic [7:0] QED_ADDR_COUNT_IDX = 8'h28;
  localparam logic [7:0] QED_ADDR_OFFSETS = 8'h29;
  localparam logic [7:0] QED_ADDR_ANGLES = 8'h2A;

  // ==========================================================
  // mode register field positions
  localparam int QED_MODE_APOL = 0;
  localparam int QED_MODE_BPOL = 1;
  localparam int QED_MODE_NPOL = 2;
  localparam int QED_MODE_QUALIFY = 3;
  localparam int QED_MODE_RELOAD = 8;
  localparam int QED_MODE_DIR = 12;
  localparam logic [31:0] QED_MODE_MASK = 32'h0000_110F;

  // ==========================================================
  // field widths and positions of wider registers
  localparam int QED_CNT_W = 24;
  localparam int QED_ANG_W = 16;
  localparam int QED_M_LSB = 0;
  localparam int QED_E_LSB = 16;

  // ==========================================================
  // values after reset
  localparam logic [31:0] QED_MODE_RST = 32'h0000_0000;
  localparam logic [23:0] QED_PPR_RST = 24'h00_1000;
  localparam logic [15:0] QED_POLES_RST = 16'h0001;
  localparam logic [31:0] QED_OFFSETS_RST = 32'h0000_0000;
  localparam logic [23:0] QED_COUNT_RST = 24'h00_0000;

  // ==========================================================
  // divider state
  typedef enum logic [0:0] {
    QED_DIV_IDLE = 1'b0,
    QED_DIV_RUN = 1'b1
  } qed_div_state_e;

endpackage

// ===== verilog/qed_divider.sv
// sequential restoring divider for the angle computation
`timescale 1ns/1ns
`default_nettype none

module qed_divider #(
  parameter int NUM_W = 40,
  parameter int DEN_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request
  input wire logic start,
  input wire logic [NUM_W-1:0] numer,
  input wire logic [DEN_W-1:0] denom,
  // answer
  output logic busy,
  output logic done,
  output logic [NUM_W-1:0] quot
);

  localparam int CW = $clog2(NUM_W + 1);
  localparam logic [CW-1:0] LAST = CW'(NUM_W - 1);

  qed_pkg::qed_div_state_e state_q;
  logic [CW-1:0] bit_q;
  logic [NUM_W-1:0] num_q;
  logic [DEN_W-1:0] den_q;
  logic [DEN_W:0] rem_q;
  logic [NUM_W-1:0] acc_q;

  // one restoring step
  wire [DEN_W:0] shifted = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};
  wire fits = shifted >= {1'b0, den_q};
  wire [DEN_W:0] rem_d = fits ? shifted - {1'b0, den_q} : shifted;
  wire [NUM_W-1:0] acc_d = {acc_q[NUM_W-2:0], fits};
  wire zero_den = den_q == '0;

  assign busy = state_q == qed_pkg::QED_DIV_RUN;

  // iteration control
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= qed_pkg::QED_DIV_IDLE;
      bit_q <= '0;
      num_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      acc_q <= '0;
      done <= 1'b0;
      quot <= '0;
    end
    else
    begin
      done <= 1'b0;
      case (state_q)
        qed_pkg::QED_DIV_IDLE:
        begin
          if (start)
          begin
            num_q <= numer;
            den_q <= denom;
            rem_q <= '0;
            acc_q <= '0;
            bit_q <= '0;
            state_q <= qed_pkg::QED_DIV_RUN;
          end
        end
        qed_pkg::QED_DIV_RUN:
        begin
          rem_q <= rem_d;
          acc_q <= acc_d;
          num_q <= {num_q[NUM_W-2:0], 1'b0};
          bit_q <= bit_q + 1'b1;
          if (bit_q == LAST)
          begin
            quot <= zero_den ? '0 : acc_d; // zero divisor gives zero
            done <= 1'b1;
            state_q <= qed_pkg::QED_DIV_IDLE;
          end
        end
        default: state_q <= qed_pkg::QED_DIV_IDLE;
      endcase
    end
  end

endmodule // qed_divider
`default_nettype wire

// ===== verification/qed_decoder_monitor.sv
// assertion checker for the decoder ports
`timescale 1ns/1ns
`default_nettype none

module qed_mon (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // outputs
  input wire logic [23:0] position,
  input wire logic [15:0] phi_mech,
  input wire logic [15:0] phi_elec,
  input wire logic index_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [31:0] mode_q;
  logic [2:0] wr_q;

  // ==========================================
  // shadow of mode and of recent writes
  always_ff @(posedge clk)
  begin
    wr_q <= {wr_q[1:0], reg_wr};
    if (!rstn)
      mode_q <= 32'h0;
    else if (reg_wr && reg_addr == qed_pkg::QED_ADDR_MODE)
      mode_q <= reg_wdata & qed_pkg::QED_MODE_MASK;
  end

  // ==========================================
  // properties
  property p_rd_mode;
    reg_rd && reg_addr == qed_pkg::QED_ADDR_MODE |=> reg_rdata == mode_q;
  endproperty
  property p_rd_cnt;
    reg_rd && reg_addr == qed_pkg::QED_ADDR_COUNT |=> reg_rdata == {8'h00, $past(position)};
  endproperty
  property p_rd_ang;
    reg_rd && reg_addr == qed_pkg::QED_ADDR_ANGLES |=> reg_rdata == {$past(phi_elec), $past(phi_mech)};
  endproperty
  property p_wr_cnt;
    reg_wr && reg_addr == qed_pkg::QED_ADDR_COUNT |=> position == 24'($past(reg_wdata));
  endproperty
  property p_idx_pol;
    index_event |-> ($past(enc_n) ^ mode_q[2]);
  endproperty
  property p_idx_qual;
    index_event && mode_q[3] |-> ($past(enc_a, 2) ^ mode_q[0]) && ($past(enc_b, 2) ^ mode_q[1]);
  endproperty
  property p_idx_once;
    index_event |=> !index_event;
  endproperty
  property p_pos_cause;
    $changed(position) |-> index_event || (|wr_q) || $past({enc_a, enc_b}, 2) != $past({enc_a, enc_b}, 3);
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode readback wrong");
  a_rd_cnt: assert property (p_rd_cnt) else $error("count readback wrong");
  a_rd_ang: assert property (p_rd_ang) else $error("angle readback wrong");
  a_wr_cnt: assert property (p_wr_cnt) else $error("count write lost");
  a_idx_pol: assert property (p_idx_pol) else $error("index at inactive level");
  a_idx_qual: assert property (p_idx_qual) else $error("index without A and B");
  a_idx_once: assert property (p_idx_once) else $error("index pulse too long");
  a_pos_cause: assert property (p_pos_cause) else $error("count moved without cause");
  c_idx: cover property (index_event);
  c_qual: cover property (index_event && mode_q[3]);
  c_wrap: cover property ($past(position) == 24'h0 && position == 24'h9);
endmodule // qed_mon

bind qed_decoder qed_mon qed_mon_i (.clk(clk), .rstn(rstn), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .position(position), .phi_mech(phi_mech), .phi_elec(phi_elec), .index_event(index_event));
`default_nettype wire

// ===== verification/qed_encoder_model.sv
// behavioural incremental encoder with A, B and index outputs
`timescale 1ns/1ns
`default_nettype none

module qed_enc (
  // clock
  input wire logic clk,
  // step and index commands
  input wire logic fwd,
  input wire logic bwd,
  input wire logic idx,
  // encoder pins
  output logic enc_a,
  output logic enc_b,
  output var logic enc_n
);
  logic [1:0] ph_q = 2'h0;

  // gray order 00, 01, 11, 10 when stepping forward
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];

  // one quarter step per command, index follows its command
  initial enc_n = 1'b0;
  always @(posedge clk)
  begin
    ph_q <= ph_q + {bwd, fwd | bwd};
    enc_n <= idx;
  end
endmodule // qed_enc
`default_nettype wire

// ===== verification/qed_decoder_bench.sv
// self-checking bench of the quadrature decoder
`timescale 1ns/1ns
`default_nettype none

module qed_decoder_bench;
  logic clk, rstn, fwd, bwd, idx, reg_wr, reg_rd, enc_a, enc_b, enc_n, index_event;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] position;
  logic [15:0] phi_mech, phi_elec;
  int n_mismatch, compares;

  qed_decoder qed_decoder_i (.clk(clk), .rstn(rstn), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .position(position), .phi_mech(phi_mech), .phi_elec(phi_elec), .index_event(index_event));
  qed_enc qed_enc_i (.clk(clk), .fwd(fwd), .bwd(bwd), .idx(idx), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));

  // ==========================================
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clk);
  endtask
  task automatic step(input logic dir, input int n);
    repeat (n)
    begin
      fwd <= dir;
      bwd <= !dir;
      @(posedge clk);
    end
    fwd <= 1'b0;
    bwd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse(input logic exp);
    idx <= 1'b1;
    @(posedge clk);
    idx <= 1'b0;
    @(posedge clk);
    #1 chk({31'h0, index_event}, {31'h0, exp});
    repeat (3) @(posedge clk);
  endtask
  task automatic results();
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #200000;
    n_mismatch++;
    results();
  end

  // ==========================================
  // test sequence
  initial
  begin
    {rstn, fwd, bwd, idx, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // values after reset and an unmapped place
    rd(8'h25, qed_pkg::QED_MODE_RST);
    rd(8'h26, {8'h00, qed_pkg::QED_PPR_RST});
    rd(8'h1B, {16'h0, qed_pkg::QED_POLES_RST});
    rd(8'h27, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h29, qed_pkg::QED_OFFSETS_RST);
    rd(8'h2A, 32'h0);
    rd(8'h30, 32'h0);
    // field masks and the read-only angle word
    wr(8'h25, 32'hFFFFFFFF);
    rd(8'h25, 32'h0000110F);
    wr(8'h25, 32'h0);
    wr(8'h26, 32'hFFFFFFFF);
    rd(8'h26, 32'h00FFFFFF);
    wr(8'h2A, 32'h1234);
    rd(8'h2A, 32'h0);
    // counting with wrap both ways, then reversed direction
    wr(8'h26, 32'h0000000A);
    wr(8'h27, 32'h00000008);
    step(1'b1, 3);
    rd(8'h27, 32'h00000001);
    step(1'b0, 2);
    rd(8'h27, 32'h00000009);
    chk({8'h00, position}, 32'h00000009);
    wr(8'h25, 32'h1000);
    step(1'b1, 1);
    rd(8'h27, 32'h00000008);
    // inverting A or B turns a forward step into a backward one
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h25, 32'h1 << i);
      wr(8'h27, 32'h00000005);
      step(1'b1, 1);
      rd(8'h27, 32'h00000004);
    end
    wr(8'h25, 32'h0);
    // index capture, inverted index, qualified index
    wr(8'h27, 32'h00000005);
    pulse(1'b1);
    rd(8'h28, 32'h00000005);
    wr(8'h25, 32'h4);
    wr(8'h27, 32'h00000007);
    pulse(1'b0);
    rd(8'h28, 32'h00000007);
    wr(8'h25, 32'h8);
    wr(8'h28, 32'h00000009);
    wr(8'h27, 32'h00000003);
    pulse(1'b0);
    rd(8'h28, 32'h00000009);
    step(1'b1, 2);
    pulse(1'b1);
    rd(8'h28, 32'h00000005);
    // reload of the count from the latch
    wr(8'h25, 32'h100);
    wr(8'h28, 32'h00000002);
    wr(8'h27, 32'h00000006);
    pulse(1'b1);
    rd(8'h27, 32'h00000002);
    // angles with offsets and pole pairs
    wr(8'h25, 32'h0);
    wr(8'h26, 32'h00000010);
    wr(8'h27, 32'h00000004);
    wr(8'h29, 32'h01000010);
    wr(8'h1B, 32'h00000003);
    repeat (100) @(posedge clk);
    chk({16'h0, phi_mech}, 32'h4010);
    chk({16'h0, phi_elec}, 32'hC130);
    rd(8'h2A, 32'hC1304010);
    results();
  end
endmodule // qed_decoder_bench
`default_nettype wire
